// *** core/cbl_pkg.sv ***
/*
 * Shared constants and types for the configuration loader and pin options.
 * Assumes a single 200 MHz core clock and a 16-bit nonvolatile store port.
 */
package cbl_pkg;

	// ****************************************************************
	// Timing.
	// ****************************************************************
	localparam int unsigned CLK_HZ         = 200_000_000; // Core clock.
	localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int unsigned WAKE_TIME_MS   = 20;          // Remote wake delay.
	localparam int unsigned LED_STRETCH_MS = 10;          // One-shot length.
	localparam int unsigned WAKE_CYCLES    = CLK_HZ / 1000 * WAKE_TIME_MS;
	localparam int unsigned LED_CYCLES     = CLK_HZ / 1000 * LED_STRETCH_MS;
	localparam int unsigned MAX_BAUD       = 3_000_000;   // Serial ceiling.
	localparam int unsigned MIN_BAUD_DIV   = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
	localparam int unsigned AUX_CLK_HZ     = 12_000_000;  // Clock output.
	// Phase step per core cycle; two steps of the modulus make one period.
	localparam logic [7:0]  CLK_PH_STEP    = 8'(2 * AUX_CLK_HZ / 1_000_000);
	localparam logic [7:0]  CLK_PH_MOD     = 8'(CLK_MHZ);

	// ****************************************************************
	// Nonvolatile store layout.
	// ****************************************************************
	localparam int unsigned NVM_AW      = 6;  // Word address width.
	localparam int unsigned NVM_DW      = 16; // Word width.
	localparam logic [5:0]  NVM_WORDS   = 6'h05;
	localparam logic [5:0]  NVM_W_PINS  = 6'h00; // Aux pins 0 to 3.
	localparam logic [5:0]  NVM_W_OPTS  = 6'h01; // Aux pin 4 and options.
	localparam logic [5:0]  NVM_W_POWER = 6'h02; // Power field.
	localparam logic [5:0]  NVM_W_VER   = 6'h03; // USB version.
	localparam logic [5:0]  NVM_W_SER   = 6'h04; // Serial number.
	localparam int unsigned OPT_INV_LSB = 4;
	localparam int unsigned OPT_PULLDN  = 12;
	localparam int unsigned OPT_RWAKE   = 13;
	localparam int unsigned OPT_EXTOSC  = 14;
	localparam int unsigned OPT_SERIAL  = 15;
	localparam int unsigned PWR_SELF    = 8;

	// ****************************************************************
	// Aux pin functions and serial line indices.
	// ****************************************************************
	typedef enum logic [3:0] {
		FN_TX_LED   = 4'h0,
		FN_RX_LED   = 4'h1,
		FN_ANY_LED  = 4'h2,
		FN_LINE_DRV = 4'h3,
		FN_PWR_EN   = 4'h4,
		FN_SLEEP    = 4'h5,
		FN_CLK12    = 4'h6
	} cbl_aux_fn_t;
	localparam int unsigned UL_TXD = 0;
	localparam int unsigned UL_RXD = 1;
	localparam int unsigned UL_RTS = 2;
	localparam int unsigned UL_CTS = 3;
	localparam int unsigned UL_DTR = 4;
	localparam int unsigned UL_DSR = 5;
	localparam int unsigned UL_CAR = 6;
	localparam int unsigned UL_RNG = 7;

	// One tri-state pin seen from inside.
	typedef struct packed {
		logic out;
		logic oe;
	} cbl_pin_t;

	// Loaded configuration image.
	typedef struct packed {
		logic [4:0][3:0] aux_fn;
		logic [7:0]      invert;
		logic            pulldown_en;
		logic            remote_wake_en;
		logic            ext_osc;
		logic            serial_en;
		logic [7:0]      max_power;    // In 2 mA units.
		logic            self_powered;
		logic [15:0]     usb_version;
		logic [15:0]     serial_num;
	} cbl_cfg_t;

	localparam cbl_cfg_t CFG_DEFAULT = '{
		aux_fn:         {FN_SLEEP, FN_PWR_EN, FN_LINE_DRV, FN_RX_LED, FN_TX_LED},
		invert:         8'h00,
		pulldown_en:    1'b0,
		remote_wake_en: 1'b1,
		ext_osc:        1'b0,
		serial_en:      1'b1,
		max_power:      8'h2d,
		self_powered:   1'b0,
		usb_version:    16'h0200,
		serial_num:     16'h0000
	};

endpackage : cbl_pkg

// *** core/cbl_config_loader.sv ***
/*
 * Configuration loader and auxiliary pin / serial line option logic.
 * Assumes pin inputs are synchronous to core_clk and that the store
 * answers each held read request with a one-cycle valid.
 */
// Overview of operation
// - Reload stored configuration after any reset.
// - Every aux pin can drive an LED.
// - Activity LED goes tri-state to low.
// - One-shot stretches brief activity visibly.
// - Combined LED shows transmit or receive.
// - Clock option gives 12 MHz output.
// - Power enable low configured, high suspended.
// - Sleep output low only during suspend.
// - Optional pull-down of serial lines in suspend.
// - Ring input low wakes host after 20 ms.
// - Each serial line has own inversion.
// - Factory default aux pin assignment.
// - Internal oscillator default, external selectable.
// - No oscillator means device does not run.
// - Serial rate capped at 3 Mbaud.
// - Version reports USB 2.0, full speed.
// - Default 90 mA, bus powered.
// - Serial number stored, reporting enabled.
// - RTS and CTS give hardware flow control.
// - Line driver enable leads start by one bit.
`timescale 1ns/1ps
module cbl_config_loader #(
	parameter int unsigned WAKE_CYCLES = cbl_pkg::WAKE_CYCLES,
	parameter int unsigned LED_CYCLES  = cbl_pkg::LED_CYCLES,
	parameter int unsigned BAUD_W      = 16
) (
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	input  wire logic                       usb_bus_reset,
	input  wire logic                       usb_configured,
	input  wire logic                       usb_suspend,
	input  wire logic                       ext_osc_present,
	output logic                            nvm_rd_req,
	output logic [cbl_pkg::NVM_AW-1:0]      nvm_rd_addr,
	input  wire logic                       nvm_rd_valid,
	input  wire logic [cbl_pkg::NVM_DW-1:0] nvm_rd_data,
	input  wire logic                       tx_data_moved,
	input  wire logic                       rx_data_moved,
	input  wire logic                       tx_char_start,
	input  wire logic                       tx_stop_bit,
	input  wire logic [15:0]                bit_cycles,
	output logic                            tx_start_go,
	input  wire logic [BAUD_W-1:0]          baud_div_req,
	output logic [BAUD_W-1:0]               baud_div,
	input  wire logic                       core_txd,
	input  wire logic                       core_rts_n,
	input  wire logic                       core_dtr_n,
	output logic                            core_rxd,
	output logic                            core_dsr_n,
	output logic                            core_carrier_n,
	output logic                            core_ring_n,
	output logic                            tx_allowed,
	output logic                            txd,
	output logic                            rts_n,
	output logic                            dtr_n,
	input  wire logic                       rxd,
	input  wire logic                       cts_n,
	input  wire logic                       dsr_n,
	input  wire logic                       carrier_detect_n,
	input  wire logic                       ring_indicator_n,
	output logic [4:0]                      aux_out,
	output logic [4:0]                      aux_oe,
	output logic                            uart_pulldown,
	output logic                            remote_wake,
	output logic                            osc_ext_select,
	output logic                            device_run,
	output logic                            cfg_loaded,
	output cbl_pkg::cbl_cfg_t               desc
);

	// ****************************************************************
	// Configuration load.
	// ****************************************************************
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_READ = 2'b01,
		LD_DONE = 2'b10
	} cbl_ld_state_t;

	cbl_ld_state_t     ld_state;   // Loader state.
	cbl_pkg::cbl_cfg_t next_desc;  // Image with the current word merged.

	// Merge the arriving word into its fields of the image.
	always_comb begin
		next_desc = desc;
		case (nvm_rd_addr)
			cbl_pkg::NVM_W_PINS: begin
				next_desc.aux_fn[3:0] = nvm_rd_data;
			end
			cbl_pkg::NVM_W_OPTS: begin
				next_desc.aux_fn[4]       = nvm_rd_data[3:0];
				next_desc.invert          = nvm_rd_data[cbl_pkg::OPT_INV_LSB +: 8];
				next_desc.pulldown_en     = nvm_rd_data[cbl_pkg::OPT_PULLDN];
				next_desc.remote_wake_en  = nvm_rd_data[cbl_pkg::OPT_RWAKE];
				next_desc.ext_osc         = nvm_rd_data[cbl_pkg::OPT_EXTOSC];
				next_desc.serial_en       = nvm_rd_data[cbl_pkg::OPT_SERIAL];
			end
			cbl_pkg::NVM_W_POWER: begin
				next_desc.max_power    = nvm_rd_data[7:0];
				next_desc.self_powered = nvm_rd_data[cbl_pkg::PWR_SELF];
			end
			cbl_pkg::NVM_W_VER: begin
				next_desc.usb_version = nvm_rd_data;
			end
			cbl_pkg::NVM_W_SER: begin
				next_desc.serial_num = nvm_rd_data;
			end
			default: begin
				next_desc = desc;
			end
		endcase
	end

	// Walk the store word by word; a bus reset restarts the walk.
	// After reset, factory values stand in the image until the store overwrites them; a bus reset keeps the old image.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ld_state    <= LD_READ;
			nvm_rd_req  <= 1'b1;
			nvm_rd_addr <= cbl_pkg::NVM_W_PINS;
			cfg_loaded  <= 1'b0;
			desc        <= cbl_pkg::CFG_DEFAULT;
		end else if (usb_bus_reset) begin
			ld_state    <= LD_READ;
			nvm_rd_req  <= 1'b1;
			nvm_rd_addr <= cbl_pkg::NVM_W_PINS;
			cfg_loaded  <= 1'b0;
		end else begin
			case (ld_state)
				LD_READ: begin
					if (nvm_rd_valid) begin
						desc <= next_desc;
						if (nvm_rd_addr == cbl_pkg::NVM_WORDS - 6'h01) begin
							ld_state   <= LD_DONE;
							nvm_rd_req <= 1'b0;
							cfg_loaded <= 1'b1;
						end else begin
							nvm_rd_addr <= nvm_rd_addr + 6'h01;
						end
					end
				end
				LD_DONE: begin
					ld_state <= LD_DONE;
				end
				default: begin
					ld_state <= LD_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Oscillator choice and serial rate ceiling.
	// ****************************************************************
	// Selecting the external source without one present stalls the part.
	wire osc_ok = !desc.ext_osc || ext_osc_present;
	wire [BAUD_W-1:0] min_div = BAUD_W'(cbl_pkg::MIN_BAUD_DIV);
	wire [BAUD_W-1:0] next_baud_div =
		(baud_div_req < min_div) ? min_div : baud_div_req;

	// Clock source follows the image only once it is loaded.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			osc_ext_select <= 1'b0;
			device_run     <= 1'b0;
			baud_div       <= BAUD_W'(cbl_pkg::MIN_BAUD_DIV);
		end else begin
			osc_ext_select <= cfg_loaded && desc.ext_osc;
			device_run     <= cfg_loaded && osc_ok;
			baud_div       <= next_baud_div;
		end
	end

	// ****************************************************************
	// Activity one-shots.
	// ****************************************************************
	logic [31:0] tx_led_cnt;  // Transmit stretch remaining.
	logic [31:0] rx_led_cnt;  // Receive stretch remaining.
	logic [31:0] any_led_cnt; // Combined stretch remaining.
	wire         tx_busy  = tx_led_cnt != 32'h0;
	wire         rx_busy  = rx_led_cnt != 32'h0;
	wire         any_busy = any_led_cnt != 32'h0;
	wire [31:0]  led_load = 32'(LED_CYCLES);

	// Each transfer reloads the count, so a steady stream holds it on.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_led_cnt  <= 32'h0;
			rx_led_cnt  <= 32'h0;
			any_led_cnt <= 32'h0;
		end else begin
			tx_led_cnt  <= tx_data_moved ? led_load :
				(tx_busy ? tx_led_cnt - 32'h1 : 32'h0);
			rx_led_cnt  <= rx_data_moved ? led_load :
				(rx_busy ? rx_led_cnt - 32'h1 : 32'h0);
			any_led_cnt <= (tx_data_moved || rx_data_moved) ? led_load :
				(any_busy ? any_led_cnt - 32'h1 : 32'h0);
		end
	end

	// ****************************************************************
	// Line driver enable, power state, 12 MHz output.
	// ****************************************************************
	logic        line_drv;  // Transceiver enable level.
	logic        leading;   // In the one-bit lead before the start bit.
	logic [15:0] lead_cnt;  // Cycles of lead remaining.
	logic        pwr_n;     // Power enable level.
	logic        sleep_n;   // Suspend indicator level.
	logic        clk12;     // Divided clock.
	logic [7:0]  clk_ph;    // Fractional phase accumulator.
	wire  [7:0]  ph_sum = clk_ph + cbl_pkg::CLK_PH_STEP;
	wire         ph_wrap = ph_sum >= cbl_pkg::CLK_PH_MOD;

	// The lead is one bit period from the request; the start bit is only
	// released by tx_start_go, so the serialiser cannot outrun the driver.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			line_drv    <= 1'b0;
			leading     <= 1'b0;
			lead_cnt    <= 16'h0;
			tx_start_go <= 1'b0;
		end else begin
			tx_start_go <= leading && lead_cnt <= 16'h1;
			if (tx_char_start && !line_drv) begin
				line_drv <= 1'b1;
				leading  <= 1'b1;
				lead_cnt <= bit_cycles;
			end else if (leading) begin
				leading  <= lead_cnt > 16'h1;
				lead_cnt <= lead_cnt - 16'h1;
			end else if (tx_stop_bit) begin
				line_drv <= 1'b0;
			end
		end
	end

	// The clock is 12 MHz on average; edges jitter by one core period
	// because 200 MHz is not a whole multiple of it.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			clk_ph  <= 8'h00;
			clk12   <= 1'b0;
			pwr_n   <= 1'b1;
			sleep_n <= 1'b1;
		end else begin
			clk_ph  <= ph_wrap ? ph_sum - cbl_pkg::CLK_PH_MOD : ph_sum;
			clk12   <= clk12 ^ ph_wrap;
			pwr_n   <= usb_suspend || !usb_configured;
			sleep_n <= !usb_suspend;
		end
	end

	// ****************************************************************
	// Auxiliary pin drive.
	// ****************************************************************
	// Map one configured function to its pin drive.
	// Levels come in as arguments, not as module signals read from inside,
	// so that the continuous assignment calling this follows every change.
	function automatic cbl_pkg::cbl_pin_t aux_drive(
		input logic [3:0] fn,    // Configured function code.
		input logic       tx_b,  // Transmit stretch running.
		input logic       rx_b,  // Receive stretch running.
		input logic       any_b, // Combined stretch running.
		input logic       drv,   // Line driver enable level.
		input logic       pwr,   // Power enable level.
		input logic       slp,   // Suspend indicator level.
		input logic       clk    // Divided clock level.
	);
		cbl_pkg::cbl_pin_t p;
		p = '{out: 1'b0, oe: 1'b0};
		case (fn)
			cbl_pkg::FN_TX_LED:   p = '{out: 1'b0, oe: tx_b};
			cbl_pkg::FN_RX_LED:   p = '{out: 1'b0, oe: rx_b};
			cbl_pkg::FN_ANY_LED:  p = '{out: 1'b0, oe: any_b};
			cbl_pkg::FN_LINE_DRV: p = '{out: drv, oe: 1'b1};
			cbl_pkg::FN_PWR_EN:   p = '{out: pwr, oe: 1'b1};
			cbl_pkg::FN_SLEEP:    p = '{out: slp, oe: 1'b1};
			cbl_pkg::FN_CLK12:    p = '{out: clk, oe: 1'b1};
			default:              p = '{out: 1'b0, oe: 1'b0};
		endcase
		return p;
	endfunction : aux_drive

	cbl_pkg::cbl_pin_t [4:0] next_aux; // Drive wanted per pin.
	for (genvar i = 0; i < 5; i++) begin : g_aux
		assign next_aux[i] = aux_drive(desc.aux_fn[i], tx_busy, rx_busy,
			any_busy, line_drv, pwr_n, sleep_n, clk12);
	end

	// Pins float until the image is loaded and a clock source exists.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			aux_out <= 5'h00;
			aux_oe  <= 5'h00;
		end else begin
			for (int i = 0; i < 5; i++) begin
				aux_out[i] <= next_aux[i].out;
				aux_oe[i]  <= next_aux[i].oe && cfg_loaded && osc_ok;
			end
		end
	end

	// ****************************************************************
	// Serial line inversion, flow control, suspend pull-down, wake.
	// ****************************************************************
	wire [7:0] inv = desc.invert;
	wire       pull = desc.pulldown_en && usb_suspend;
	wire       ring_low = (ring_indicator_n ^ inv[cbl_pkg::UL_RNG]) == 1'b0;
	logic        wake_pend; // Ring seen, delay running.
	logic [31:0] wake_cnt;  // Delay cycles elapsed.

	// Each line passes through its own inverter; pull-down wins in suspend.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			txd            <= 1'b1;
			rts_n          <= 1'b1;
			dtr_n          <= 1'b1;
			core_rxd       <= 1'b1;
			core_dsr_n     <= 1'b1;
			core_carrier_n <= 1'b1;
			core_ring_n    <= 1'b1;
			tx_allowed     <= 1'b0;
			uart_pulldown  <= 1'b0;
		end else begin
			txd   <= !pull && (core_txd ^ inv[cbl_pkg::UL_TXD]);
			rts_n <= !pull && (core_rts_n ^ inv[cbl_pkg::UL_RTS]);
			dtr_n <= !pull && (core_dtr_n ^ inv[cbl_pkg::UL_DTR]);
			core_rxd       <= rxd ^ inv[cbl_pkg::UL_RXD];
			core_dsr_n     <= dsr_n ^ inv[cbl_pkg::UL_DSR];
			core_carrier_n <= carrier_detect_n ^ inv[cbl_pkg::UL_CAR];
			core_ring_n    <= !ring_low;
			tx_allowed     <= (cts_n ^ inv[cbl_pkg::UL_CTS]) == 1'b0;
			uart_pulldown  <= pull;
		end
	end

	// The delay restarts whenever suspend ends or the option is off.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wake_pend   <= 1'b0;
			wake_cnt    <= 32'h0;
			remote_wake <= 1'b0;
		end else if (!usb_suspend || !desc.remote_wake_en) begin
			wake_pend   <= 1'b0;
			wake_cnt    <= 32'h0;
			remote_wake <= 1'b0;
		end else begin
			remote_wake <= wake_pend && wake_cnt == 32'(WAKE_CYCLES) - 32'h1;
			if (wake_pend) begin
				wake_pend <= wake_cnt != 32'(WAKE_CYCLES) - 32'h1;
				wake_cnt  <= wake_cnt + 32'h1;
			end else if (ring_low) begin
				wake_pend <= 1'b1;
				wake_cnt  <= 32'h0;
			end
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_bus_reset_reload: assert property (usb_bus_reset |=> !cfg_loaded)
		else $error("Bus reset did not restart the load.");
	a_aux_float_early: assert property (!cfg_loaded |=> aux_oe == 5'h00)
		else $error("Aux pin driven before load.");
	a_tx_led_on: assert property (cfg_loaded && osc_ok && !usb_bus_reset
		&& desc.aux_fn[0] == cbl_pkg::FN_TX_LED && tx_data_moved
		|=> ##1 aux_oe[0] && !aux_out[0])
		else $error("Transmit LED did not light.");
	a_led_stretch: assert property (tx_data_moved |=> tx_busy [*8])
		else $error("Activity stretch too short.");
	a_any_led: assert property (rx_data_moved |=> any_busy)
		else $error("Combined LED missed receive.");
	a_pwr_suspend: assert property (usb_suspend |=> pwr_n && !sleep_n)
		else $error("Power or sleep level wrong in suspend.");
	a_pulldown_txd: assert property (uart_pulldown |-> !txd)
		else $error("Transmit line not pulled low.");
	a_baud_floor: assert property (baud_div >= min_div)
		else $error("Serial divisor below ceiling rate.");
	a_lead_before: assert property (tx_start_go |-> line_drv)
		else $error("Start released without line driver.");
	a_no_osc_halt: assert property (!osc_ok |=> !device_run)
		else $error("Device runs without oscillator.");

endmodule : cbl_config_loader

// *** bench/cbl_nvm_model.sv ***
/*
 * Model of the nonvolatile store that feeds the configuration loader.
 * Assumes the loader holds each read request until the one-cycle valid.
 */
`timescale 1ns/1ps
module cbl_nvm_model (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        nvm_rd_req,
	input  wire logic [5:0]  nvm_rd_addr,
	input  wire logic [79:0] image,
	input  wire logic [3:0]  slow,
	output logic             nvm_rd_valid,
	output logic [15:0]      nvm_rd_data
);
	// ****************************************************************
	// Read answer.
	// ****************************************************************
	logic [3:0] wait_cnt; // Cycles already spent on this request.

	// Valid is a single-cycle pulse after slow idle cycles; outside it the
	// data lines toggle so that stale words never look good.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			nvm_rd_valid <= 1'b0;
			wait_cnt     <= 4'h0;
			nvm_rd_data  <= 16'h0000;
		end else if (!nvm_rd_valid && nvm_rd_req && wait_cnt >= slow) begin
			nvm_rd_valid <= 1'b1;
			nvm_rd_data  <= image[int'(nvm_rd_addr) * 16 +: 16];
			wait_cnt     <= 4'h0;
		end else begin
			nvm_rd_valid <= 1'b0;
			nvm_rd_data  <= ~nvm_rd_data;
			if (nvm_rd_req) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule : cbl_nvm_model

// *** bench/tb.sv ***
/*
 * Self-checking bench for the configuration loader and pin options.
 * Assumes the store model above and shortened one-shot and wake counts.
 */
`timescale 1ns/1ps
module tb;
	localparam int LC = 16; // Shortened one-shot length.
	localparam int WC = 32; // Shortened wake delay.
	// Store images, word 0 at the bottom.
	localparam logic [79:0] IMG_DEF = 80'h1234_0200_002d_a005_4310;
	localparam logic [79:0] IMG_LED = 80'h1234_0200_0132_3ff2_2222;
	localparam logic [79:0] IMG_OSC = 80'h1234_0200_002d_e005_4316;
	logic core_clk, reset, usb_bus_reset, usb_configured, usb_suspend;
	logic ext_osc_present, nvm_rd_req, nvm_rd_valid, tx_data_moved;
	logic rx_data_moved, tx_char_start, tx_stop_bit, tx_start_go;
	logic core_txd, core_rts_n, core_dtr_n, core_rxd, core_dsr_n;
	logic core_carrier_n, core_ring_n, tx_allowed, txd, rts_n, dtr_n;
	logic rxd, cts_n, dsr_n, carrier_detect_n, ring_indicator_n;
	logic uart_pulldown, remote_wake, osc_ext_select, device_run;
	logic cfg_loaded;
	logic [5:0] nvm_rd_addr;
	logic [15:0] nvm_rd_data, bit_cycles, baud_div_req, baud_div;
	logic [4:0] aux_out, aux_oe;
	logic [79:0] image;
	logic [3:0] slow;
	cbl_pkg::cbl_cfg_t desc;
	int n_fail, checked, cycles, wakes;

	cbl_config_loader #(.WAKE_CYCLES(WC), .LED_CYCLES(LC)) dut_u (
		.core_clk, .reset, .usb_bus_reset, .usb_configured, .usb_suspend,
		.ext_osc_present, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_valid,
		.nvm_rd_data, .tx_data_moved, .rx_data_moved, .tx_char_start,
		.tx_stop_bit, .bit_cycles, .tx_start_go, .baud_div_req, .baud_div,
		.core_txd, .core_rts_n, .core_dtr_n, .core_rxd, .core_dsr_n,
		.core_carrier_n, .core_ring_n, .tx_allowed, .txd, .rts_n, .dtr_n,
		.rxd, .cts_n, .dsr_n, .carrier_detect_n, .ring_indicator_n,
		.aux_out, .aux_oe, .uart_pulldown, .remote_wake, .osc_ext_select,
		.device_run, .cfg_loaded, .desc);
	cbl_nvm_model nvm_u (.core_clk, .reset, .nvm_rd_req, .nvm_rd_addr,
		.image, .slow, .nvm_rd_valid, .nvm_rd_data);

	// Clock, hang guard and a count of wake pulses.
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		wakes += (remote_wake === 1'b1);
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask : step

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report

	// Wait for a load to finish, then one edge for the pins to follow.
	task automatic wait_load();
		int n;
		n = 0;
		while (cfg_loaded !== 1'b1 && n < 200) begin
			step(1);
			#1;
			n++;
		end
		chk("cfg_loaded", 1, cfg_loaded);
		step(1);
		#1;
	endtask : wait_load

	// Restart the load with a bus reset and a new store image.
	task automatic load(input logic [79:0] img, input logic [3:0] sl);
		step(1);
		image <= img;
		slow <= sl;
		usb_bus_reset <= 1'b1;
		step(1);
		usb_bus_reset <= 1'b0;
		// The pins follow the dropped load flag one edge after the restart.
		step(1);
		#1;
		chk("oe in load", 0, aux_oe);
		wait_load();
	endtask : load

	// One transfer pulse; returns two edges after it was taken.
	task automatic act(input logic t, input logic r);
		step(1);
		tx_data_moved <= t;
		rx_data_moved <= r;
		step(1);
		tx_data_moved <= 1'b0;
		rx_data_moved <= 1'b0;
		step(2);
		#1;
	endtask : act

	task automatic t_reset_load();
		chk("oe in reset", 0, aux_oe);
		step(1);
		reset <= 1'b0;
		wait_load();
		chk("version", 16'h0200, desc.usb_version);
		chk("power", 16'h002d, desc.max_power);
		chk("self", 0, desc.self_powered);
		chk("serial", 16'h1234, desc.serial_num);
		chk("ser en", 1, desc.serial_en);
		chk("ext osc", 0, osc_ext_select);
		chk("run", 1, device_run);
		chk("oe", 5'h1c, aux_oe);
		chk("out", 3'b110, aux_out[4:2]);
		chk("rxd", 1, core_rxd);
		chk("cts", 0, tx_allowed);
	endtask : t_reset_load

	task automatic t_activity();
		act(1'b1, 1'b0);
		chk("tx led", 2'b01, aux_oe[1:0]);
		chk("tx out", 0, aux_out[0]);
		step(LC / 2);
		act(1'b1, 1'b0);
		step(LC - 2);
		#1;
		chk("retrig", 1, aux_oe[0]);
		step(4);
		#1;
		chk("release", 0, aux_oe[0]);
		act(1'b0, 1'b1);
		chk("rx led", 2'b10, aux_oe[1:0]);
		step(LC + 2);
		#1;
		chk("rx off", 0, aux_oe[1]);
	endtask : t_activity

	task automatic t_combined();
		load(IMG_LED, 4'h2);
		chk("power", 16'h0132, {desc.self_powered, desc.max_power});
		act(1'b1, 1'b0);
		chk("all tx", 5'h1f, aux_oe);
		step(LC + 2);
		act(1'b0, 1'b1);
		chk("all rx", 5'h1f, aux_oe);
		chk("all low", 0, aux_out);
		chk("inv out", 3'b111, {txd, rts_n, dtr_n});
		chk("inv in", 0,
			{core_rxd, core_dsr_n, core_carrier_n, core_ring_n});
		chk("cts inv", 1, tx_allowed);
		usb_suspend <= 1'b1;
		step(2);
		#1;
		chk("pulldown", 4'h8, {uart_pulldown, txd, rts_n, dtr_n});
		wakes = 0;
		usb_suspend <= 1'b0;
		step(WC + 4);
		chk("wake abort", 0, wakes);
	endtask : t_combined

	task automatic t_power();
		int n;
		load(IMG_DEF, 4'h0);
		chk("pwr unconf", 1, aux_out[3]);
		usb_configured <= 1'b1;
		step(2);
		#1;
		chk("pwr conf", 2'b10, aux_out[4:3]);
		usb_suspend <= 1'b1;
		step(2);
		#1;
		chk("suspend", 3'b001, {uart_pulldown, aux_out[4:3]});
		ring_indicator_n <= 1'b0;
		n = 0;
		while (remote_wake !== 1'b1 && n < WC + 10) begin
			step(1);
			#1;
			n++;
		end
		chk("wake delay", 1, n >= WC && n <= WC + 2);
		ring_indicator_n <= 1'b1;
		usb_suspend <= 1'b0;
	endtask : t_power

	task automatic t_line_drv();
		int n;
		step(1);
		tx_char_start <= 1'b1;
		step(1);
		tx_char_start <= 1'b0;
		step(1);
		#1;
		chk("lead", 1, aux_out[2]);
		n = 1;
		while (tx_start_go !== 1'b1 && n < 20) begin
			step(1);
			#1;
			n++;
		end
		chk("go delay", bit_cycles, 16'(n));
		step(1);
		tx_stop_bit <= 1'b1;
		step(1);
		tx_stop_bit <= 1'b0;
		step(1);
		#1;
		chk("drv off", 0, aux_out[2]);
	endtask : t_line_drv

	task automatic t_osc_baud();
		int n;
		logic prev;
		load(IMG_OSC, 4'h1);
		chk("ext osc", 1, osc_ext_select);
		chk("no osc", 6'h00, {device_run, aux_oe});
		ext_osc_present <= 1'b1;
		step(2);
		#1;
		chk("osc run", 1, device_run);
		// Fifty core cycles are three periods at 12 MHz, so six edges.
		n = 0;
		prev = aux_out[0];
		repeat (50) begin
			step(1);
			#1;
			n += (aux_out[0] !== prev);
			prev = aux_out[0];
		end
		chk("clk edges", 16'h0006, 16'(n));
		chk("clk oe", 1, aux_oe[0]);
		baud_div_req <= 16'h000a;
		step(2);
		#1;
		chk("baud min", 16'(cbl_pkg::MIN_BAUD_DIV), baud_div);
		baud_div_req <= 16'h00c8;
		step(2);
		#1;
		chk("baud", 16'h00c8, baud_div);
	endtask : t_osc_baud

	initial begin
		{core_clk, usb_bus_reset, usb_configured, usb_suspend} = 4'h0;
		{tx_data_moved, rx_data_moved, tx_char_start, tx_stop_bit} = 4'h0;
		{core_txd, core_rts_n, core_dtr_n, ext_osc_present} = 4'h0;
		{rxd, cts_n, dsr_n, carrier_detect_n, ring_indicator_n} = 5'h1f;
		{n_fail, checked, cycles, wakes} = '0;
		reset = 1'b1;
		image = IMG_DEF;
		slow = 4'h0;
		bit_cycles = 16'h0003;
		baud_div_req = 16'h0100;
		step(20);
		t_reset_load();
		t_activity();
		t_line_drv();
		t_power();
		t_combined();
		t_osc_baud();
		final_report();
	end
endmodule : tb
